// file: rtl/acl_core.sv
// control, readout and protection sequencing of the converter
// assumes the host pins arrive asynchronously; sample core is same-clock
`timescale 1ns/1ns
`include "acl_cfg.svh"
module acl_core #(
  parameter int DATA_W  = `ACL_DATA_W,
  parameter int CONV_C  = `ACL_CONV_CYC,
  parameter int EOC_C   = `ACL_EOC_CYC,
  parameter int OFF_C   = `ACL_OFF_CYC,
  parameter int REC_C   = `ACL_REC_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              chip_select_n,
  input  wire logic              read_convert,
  input  wire logic              surge,
  input  wire logic [DATA_W-1:0] sample,
  output logic                   busy_n,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe,
  output logic                   latchup_protection,
  output logic                   sample_ready
);
  initial
  begin
    if (DATA_W != 16 || CONV_C < 2 || EOC_C < `ACL_DATA_CYC + 1 ||
        OFF_C < 1 || REC_C < 1)
      $error("acl_core: unsupported parameters");
  end

  localparam int CW = $clog2(REC_C + CONV_C + 2);

  // two-stage synchronisers for pins
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic       rc_prev_q;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q      <= 3'h3;
      s2_q      <= 3'h3;
      rc_prev_q <= 1'b1;
    end
    else
    begin
      s1_q      <= {surge, read_convert, chip_select_n};
      s2_q      <= s1_q;
      rc_prev_q <= s2_q[1];
    end
  end
  wire cs_n  = s2_q[0];
  wire rc    = s2_q[1];
  wire surge_s = s2_q[2];

  // two-entry buffer between sampler and result register
  acl_pkg::acl_res_t buf_q [2];
  acl_pkg::acl_res_t buf_d [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       wr_v;
  logic       rd_r;
  assign sample_ready = (cnt_q != 2'h2);

  acl_pkg::acl_state_t st_q;
  acl_pkg::acl_state_t st_d;
  logic [CW-1:0]       tmr_q;
  logic [CW-1:0]       tmr_d;
  logic [DATA_W-1:0]   res_q;
  logic [DATA_W-1:0]   res_d;
  logic                busy_n_q;
  logic                busy_n_d;
  logic                lp_q;
  logic                lp_d;

  wire start = busy_n_q && !rc && (cs_n || rc_prev_q);

  // buffer next state: capture at sample point, drain at end of conversion
  always_comb
  begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    wr_v  = (st_q == acl_pkg::ACL_CONV) && (tmr_q == CW'(1));
    rd_r  = (st_q == acl_pkg::ACL_EOC) && (tmr_q == CW'(`ACL_DATA_CYC));
    if (rd_r && cnt_q != 2'h0)
    begin
      buf_d[0] = buf_q[1];
      cnt_d    = cnt_q - 2'h1;
    end
    if (wr_v && sample_ready)
    begin
      buf_d[cnt_d[0]] = '{ok: 1'b1, word: sample};
      cnt_d           = cnt_d + 2'h1;
    end
    if (st_q == acl_pkg::ACL_OFF)
      cnt_d = 2'h0; // contents lost with power
  end

  // sequencing of conversion and power cycling
  always_comb
  begin
    st_d     = st_q;
    tmr_d    = (tmr_q != '0) ? tmr_q - CW'(1) : tmr_q;
    res_d    = res_q;
    busy_n_d = busy_n_q;
    lp_d     = lp_q;
    case (st_q)
      acl_pkg::ACL_IDLE:
      begin
        if (start)
        begin
          st_d     = acl_pkg::ACL_CONV;
          tmr_d    = CW'(CONV_C);
          busy_n_d = 1'b0;
        end
      end
      acl_pkg::ACL_CONV:
      begin
        if (tmr_q == '0)
        begin
          st_d  = acl_pkg::ACL_EOC;
          tmr_d = CW'(EOC_C);
        end
      end
      acl_pkg::ACL_EOC:
      begin
        if (rd_r && cnt_q != 2'h0)
          res_d = buf_q[0].word;
        if (tmr_q == '0)
        begin
          st_d     = acl_pkg::ACL_IDLE;
          busy_n_d = 1'b1;
        end
      end
      acl_pkg::ACL_OFF:
      begin
        if (tmr_q == '0)
        begin
          st_d  = acl_pkg::ACL_REC;
          tmr_d = CW'(REC_C);
        end
      end
      acl_pkg::ACL_REC:
      begin
        if (tmr_q == '0)
        begin
          st_d = acl_pkg::ACL_IDLE;
          lp_d = 1'b0;
        end
      end
      default:
      begin
        st_d = acl_pkg::ACL_IDLE;
      end
    endcase
    // surge overrides everything outside ACL_OFF: remove power; a surge during recovery
    // restarts the cycle, so the trip wins over the status clear
    if (surge_s && st_q != acl_pkg::ACL_OFF)
    begin
      st_d     = acl_pkg::ACL_OFF;
      tmr_d    = CW'(OFF_C);
      lp_d     = 1'b1;
      busy_n_d = 1'b1;
      res_d    = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q     <= acl_pkg::ACL_IDLE;
      tmr_q    <= '0;
      res_q    <= '0;
      busy_n_q <= 1'b1;
      lp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      st_q     <= st_d;
      tmr_q    <= tmr_d;
      res_q    <= res_d;
      busy_n_q <= busy_n_d;
      lp_q     <= lp_d;
      cnt_q    <= cnt_d;
      buf_q    <= buf_d;
    end
  end

  // bus drive: only with chip select low and rc high, never while off
  always_comb
  begin
    data_oe = !cs_n && rc && !lp_q;
    data_o  = res_q;
  end
  assign busy_n             = busy_n_q;
  assign latchup_protection = lp_q;
endmodule : acl_core

// file: rtl/acl_cfg.svh
// constants for the converter control and readout block
// assumes a 100 MHz ref_clk; times are printed figures, counts derived
// Overview of operation
// - chip select high, convert high: no operation, bus released
// - cs high, convert low, idle: start, bus released
// - cs low, convert falling, idle: start, release
// - conversion done, cs low, rc high: drive result
// - during conversion, read shows previous result
// - busy low: ignore every convert request
// - data valid within 8 us of start
// - busy falls within 85 ns of start
// - busy rises at least 50 ns after data
// - busy rises about 220 ns after conversion end
// - previous result readable about 7.4 us
// - sixteen parallel lines, bit 15 most significant
// - supply surge: power off, then back on
// - status high while protected power removed
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
`define ACL_CLK_PERIOD_NS   10
`define ACL_CONV_MAX_NS     8000
`define ACL_PREV_VALID_NS   7400
`define ACL_BUSY_FALL_NS    85
`define ACL_BUSY_EOC_NS     220
`define ACL_BUSY_DATA_NS    50
`define ACL_PWR_OFF_NS      1000
`define ACL_PWR_REC_NS      50000
// longest times round down, least times round up
`define ACL_CONV_CYC  (`ACL_PREV_VALID_NS / `ACL_CLK_PERIOD_NS)
`define ACL_EOC_CYC   (`ACL_BUSY_EOC_NS / `ACL_CLK_PERIOD_NS)
`define ACL_DATA_CYC  \
  ((`ACL_BUSY_DATA_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_OFF_CYC   (`ACL_PWR_OFF_NS / `ACL_CLK_PERIOD_NS)
`define ACL_REC_CYC   (`ACL_PWR_REC_NS / `ACL_CLK_PERIOD_NS)
`define ACL_DATA_W    16
`endif

// file: rtl/acl_pkg.sv
// types for the converter control and readout block
// assumes acl_cfg.svh is included by the user of these types
package acl_pkg;
  typedef enum logic [4:0]
  {
    ACL_IDLE = 5'h01,
    ACL_CONV = 5'h02,
    ACL_EOC  = 5'h04,
    ACL_OFF  = 5'h08,
    ACL_REC  = 5'h10
  } acl_state_t;
  // one result word with its valid mark
  typedef struct packed
  {
    logic        ok;
    logic [15:0] word;
  } acl_res_t;
endpackage : acl_pkg

// file: test/acl_core_properties.sv
// port assertions for the converter control block
// assumes a bind onto acl_core with a 16-bit result
`timescale 1ns/1ns
module acl_core_properties (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        chip_select_n,
  input wire logic        read_convert,
  input wire logic        surge,
  input wire logic        busy_n,
  input wire logic [15:0] data_o,
  input wire logic        data_oe,
  input wire logic        latchup_protection
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // three edges cover the pin synchroniser
  a_desel_bus_off: assert property (chip_select_n [*3] |-> !data_oe)
    else $error("bus driven while deselected");
  a_conv_bus_off: assert property (!read_convert [*3] |-> !data_oe)
    else $error("bus driven during convert");
  a_busy_fall: assert property ($fell(read_convert) && busy_n
    && !latchup_protection && !surge |-> ##[1:8] !busy_n)
    else $error("busy late after start");
  a_conv_bound: assert property ($fell(busy_n) |-> ##[1:800] busy_n)
    else $error("conversion too long");
  a_data_settle: assert property ($rose(busy_n) && !latchup_protection
    |-> data_o == $past(data_o, 5))
    else $error("data changed too close to busy rise");
  a_prev_held: assert property ($fell(busy_n) |=> $stable(data_o) [*8])
    else $error("previous result lost early");
  a_status_up: assert property ($rose(surge) |-> ##[1:4] latchup_protection)
    else $error("status late after surge");
  a_power_cycle: assert property ($rose(latchup_protection) |=>
    latchup_protection [*8] ##[1:1000] !latchup_protection)
    else $error("power cycle length wrong");
  a_status_quiet: assert property (latchup_protection |-> !data_oe)
    else $error("bus driven while powered off");
  c_convert: cover property ($fell(busy_n));
  c_read_busy: cover property (data_oe && !busy_n);
  c_protect: cover property ($rose(latchup_protection));
endmodule : acl_core_properties
bind acl_core acl_core_properties u_props (.ref_clk(ref_clk), .arst_n(arst_n),
  .chip_select_n(chip_select_n), .read_convert(read_convert), .surge(surge),
  .busy_n(busy_n), .data_o(data_o), .data_oe(data_oe),
  .latchup_protection(latchup_protection));

// file: test/acl_host_model.sv
// host processor model driving select and read/convert
// assumes go is changed by non-blocking assignment at the falling edge
`timescale 1ns/1ns
module acl_host_model (
  input  wire logic ref_clk,
  input  wire logic go,
  input  wire logic sel,
  input  wire logic latchup_protection,
  output logic      chip_select_n,
  output logic      read_convert
);
  logic [2:0] low_q = 3'h0;
  // four-cycle convert pulse, longer than the minimum width
  always @(negedge ref_clk)
    low_q <= go ? 3'h4 : (low_q != 3'h0 ? low_q - 3'h1 : 3'h0);
  // pins pulled low at once while power is off, never driven high
  assign read_convert  = (low_q == 3'h0) && !latchup_protection;
  assign chip_select_n = !sel && !latchup_protection;
endmodule : acl_host_model

// file: test/tb_top.sv
// self-checking bench for the converter control block
// assumes the host model and the bound port checker
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        go = 1'b0;
  logic        sel = 1'b0;
  logic        surge = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic        chip_select_n, read_convert, busy_n, data_oe, latchup_protection;
  logic [15:0] data_o;
  logic        sample_ready;
  int          failures = 0;
  int          checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  // short counts keep each conversion near thirty cycles
  acl_core #(.CONV_C(20), .EOC_C(6), .OFF_C(4), .REC_C(10)) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .chip_select_n(chip_select_n),
    .read_convert(read_convert), .surge(surge), .sample(sample),
    .busy_n(busy_n), .data_o(data_o), .data_oe(data_oe),
    .latchup_protection(latchup_protection), .sample_ready(sample_ready));
  acl_host_model u_host (.ref_clk(ref_clk), .go(go), .sel(sel),
    .latchup_protection(latchup_protection), .chip_select_n(chip_select_n),
    .read_convert(read_convert));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // bounded wait; a hang counts as a mismatch
  task automatic wait_for(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 2000)
    begin
      failures++;
      end_of_test();
    end
  endtask : wait_for
  // one convert pulse, only requested with busy high
  task automatic convert(logic [15:0] val);
    sample = val;
    go <= 1'b1;
    @(negedge ref_clk);
    go <= 1'b0;
    wait_for(busy_n, 1'b0);
  endtask : convert
  task automatic t_deselected();
    sel = 1'b0;
    convert(16'h8001);
    check("oe converting", data_oe, 1'b0);
    wait_for(busy_n, 1'b1);
    check("oe deselected", data_oe, 1'b0);
    sel = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("oe read", data_oe, 1'b1);
    check("result", data_o, 16'h8001);
    check("buffer room", sample_ready, 1'b1);
  endtask : t_deselected
  task automatic t_back_to_back();
    convert(16'h1234);
    check("oe at start", data_oe, 1'b0);
    repeat (8) @(negedge ref_clk);
    check("previous", data_o, 16'h8001);
    go <= 1'b1;
    @(negedge ref_clk);
    go <= 1'b0;
    wait_for(busy_n, 1'b1);
    repeat (2) @(negedge ref_clk);
    check("new result", data_o, 16'h1234);
    repeat (30) @(negedge ref_clk);
    check("no extra start", busy_n, 1'b1);
  endtask : t_back_to_back
  task automatic t_surge();
    surge = 1'b1;
    repeat (5) @(negedge ref_clk);
    surge = 1'b0;
    check("status", latchup_protection, 1'b1);
    check("oe off", data_oe, 1'b0);
    wait_for(latchup_protection, 1'b0);
    check("idle after", busy_n, 1'b1);
    convert(16'hFFFE);
    wait_for(busy_n, 1'b1);
    repeat (2) @(negedge ref_clk);
    check("after recovery", data_o, 16'hFFFE);
  endtask : t_surge
  initial
  begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_deselected();
    t_back_to_back();
    t_surge();
    end_of_test();
  end
endmodule : tb_top
